// ==== hdl/agccs_pkg.sv ====
`default_nettype none
package agccs_pkg;

	// ========================================
	// register map
	localparam int unsigned ADDR_W                  = 8;
	localparam int unsigned DATA_W                  = 8;
	localparam logic [7:0]  GAIN_CEILING_TARGET_OFS = 8'h1b;
	localparam logic [7:0]  PRIO_CS_OFS             = 8'h1c;
	localparam logic [7:0]  GAIN_CEILING_TARGET_RST = 8'h03;
	localparam logic [7:0]  PRIO_CS_RST             = 8'h40;

	// ========================================
	// field positions
	localparam int unsigned DIGITAL_CEIL_POS = 6;
	localparam int unsigned FRONT_CEIL_POS   = 3;
	localparam int unsigned AMP_TARGET_POS   = 0;
	localparam int unsigned PRIORITY_POS     = 6;
	localparam int unsigned REL_CS_POS       = 4;
	localparam int unsigned ABS_CS_POS       = 0;

	// ========================================
	// gain ranges and codes
	localparam logic [2:0] DIGITAL_TOP_STEP   = 3'h7;
	localparam logic [2:0] FRONT_MAX_RED      = 3'h7;
	localparam logic [3:0] ABS_CS_DISABLE     = 4'h8;
	localparam logic [1:0] REL_CS_DISABLE     = 2'h0;

	typedef struct packed {
		logic [1:0] digital_gain_ceiling;
		logic [2:0] front_amp_gain_ceiling;
		logic [2:0] amplitude_target;
	} agccs_ceiling_target_t;

	typedef struct packed {
		logic       reserved;
		logic       amp_stage_priority;
		logic [1:0] relative_cs_threshold;
		logic [3:0] absolute_cs_threshold;
	} agccs_prio_cs_t;

	typedef struct packed {
		logic [2:0] digital_gain_step;
		logic [2:0] first_amp_reduction;
		logic [2:0] second_amp_reduction;
	} agccs_gain_t;

	// amplitude target code to dB
	function automatic logic [7:0] agccs_target_db(input logic [2:0] code);
		logic [7:0] db;
		case (code)
			3'h0: db = 8'h18;
			3'h1: db = 8'h1b;
			3'h2: db = 8'h1e;
			3'h3: db = 8'h21;
			3'h4: db = 8'h24;
			3'h5: db = 8'h26;
			3'h6: db = 8'h28;
			default: db = 8'h2a;
		endcase
		return db;
	endfunction

	// relative carrier sense code to dB rise
	function automatic logic [7:0] agccs_rel_db(input logic [1:0] code);
		logic [7:0] db;
		case (code)
			2'h1: db = 8'h06;
			2'h2: db = 8'h0a;
			default: db = 8'h0e;
		endcase
		return db;
	endfunction

endpackage

`default_nettype wire

// ==== hdl/agccs_cfg.sv ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - digital gain ceiling code N removes the top N digital gain steps.
// - front gain ceiling code caps both stages' combined gain below full.
// - gain loop steers averaged filter amplitude toward the target.
// - target codes 0..7 mean 24,27,30,33,36,38,40,42 dB; reset is 3.
// - priority one, reset value: reduce first stage before second stage.
// - priority zero: drive second stage to minimum, then reduce first stage.
// - relative threshold zero, reset value, disables relative carrier sense.
// - relative codes 1,2,3 assert sense on 6,10,14 dB strength rise.
// - absolute threshold is signed dB offset from target; sense at that level.
// - code -8 disables absolute sense; -7..+7 offsets that many dB.
module agccs_cfg
	import agccs_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// averaged channel filter amplitude, dB
	input  wire logic              amp_valid,
	input  wire logic [7:0]        amp_level,
	// received strength, dB
	input  wire logic              received_strength_value_valid,
	input  wire logic [7:0]        received_strength_value,
	input  wire logic              cs_restart,
	// gain and sense outputs
	output agccs_gain_t            gain,
	output logic                   carrier_sense
);

	// ========================================
	// register file
	agccs_ceiling_target_t ceil_tgt;
	agccs_ceiling_target_t next_ceil_tgt;
	agccs_prio_cs_t        prio_cs;
	agccs_prio_cs_t        next_prio_cs;
	logic [DATA_W-1:0]     next_reg_rdata;

	always_comb
	begin
		next_ceil_tgt  = ceil_tgt;
		next_prio_cs   = prio_cs;
		next_reg_rdata = '0;
		if (reg_wr && reg_addr == GAIN_CEILING_TARGET_OFS)
		begin
			next_ceil_tgt = reg_wdata;
		end
		if (reg_wr && reg_addr == PRIO_CS_OFS)
		begin
			next_prio_cs          = reg_wdata;
			// top bit is reserved and always reads zero
			next_prio_cs.reserved = 1'b0;
		end
		if (reg_rd)
		begin
			case (reg_addr)
				GAIN_CEILING_TARGET_OFS: next_reg_rdata = ceil_tgt;
				PRIO_CS_OFS:             next_reg_rdata = prio_cs;
				default:                 next_reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ceil_tgt  <= GAIN_CEILING_TARGET_RST;
			prio_cs   <= PRIO_CS_RST;
			reg_rdata <= '0;
		end
		else
		begin
			ceil_tgt  <= next_ceil_tgt;
			prio_cs   <= next_prio_cs;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ========================================
	// gain control
	logic [2:0] digital_max;
	logic [3:0] front_total;
	logic [7:0] target_db;
	logic       front_can_drop;
	logic       front_can_raise;
	agccs_gain_t next_gain;

	assign digital_max = DIGITAL_TOP_STEP - {1'b0, ceil_tgt.digital_gain_ceiling};
	assign front_total = {1'b0, gain.first_amp_reduction} + {1'b0, gain.second_amp_reduction};
	assign target_db   = agccs_target_db(ceil_tgt.amplitude_target);
	assign front_can_drop  = (gain.first_amp_reduction != FRONT_MAX_RED)
		|| (gain.second_amp_reduction != FRONT_MAX_RED);
	// raising is allowed only while the combined cut stays at or above the ceiling
	assign front_can_raise = front_total > {1'b0, ceil_tgt.front_amp_gain_ceiling};

	function automatic agccs_gain_t reduce_front(input agccs_gain_t g, input logic first_prio);
		agccs_gain_t r;
		r = g;
		if (first_prio)
		begin
			if (g.first_amp_reduction != FRONT_MAX_RED)
				r.first_amp_reduction = g.first_amp_reduction + 3'h1;
			else if (g.second_amp_reduction != FRONT_MAX_RED)
				r.second_amp_reduction = g.second_amp_reduction + 3'h1;
		end
		else
		begin
			if (g.second_amp_reduction != FRONT_MAX_RED)
				r.second_amp_reduction = g.second_amp_reduction + 3'h1;
			else if (g.first_amp_reduction != FRONT_MAX_RED)
				r.first_amp_reduction = g.first_amp_reduction + 3'h1;
		end
		return r;
	endfunction

	// gain comes back in the reverse order it was taken away
	function automatic agccs_gain_t restore_front(input agccs_gain_t g, input logic first_prio);
		agccs_gain_t r;
		r = g;
		if (first_prio)
		begin
			if (g.second_amp_reduction != 3'h0)
				r.second_amp_reduction = g.second_amp_reduction - 3'h1;
			else if (g.first_amp_reduction != 3'h0)
				r.first_amp_reduction = g.first_amp_reduction - 3'h1;
		end
		else
		begin
			if (g.first_amp_reduction != 3'h0)
				r.first_amp_reduction = g.first_amp_reduction - 3'h1;
			else if (g.second_amp_reduction != 3'h0)
				r.second_amp_reduction = g.second_amp_reduction - 3'h1;
		end
		return r;
	endfunction

	always_comb
	begin
		next_gain = gain;
		if (gain.digital_gain_step > digital_max)
		begin
			// a lowered ceiling takes effect at once, not on the next amplitude sample
			next_gain.digital_gain_step = digital_max;
		end
		else if (front_total < {1'b0, ceil_tgt.front_amp_gain_ceiling})
		begin
			next_gain = reduce_front(gain, prio_cs.amp_stage_priority);
		end
		else if (amp_valid && amp_level > target_db)
		begin
			if (front_can_drop)
				next_gain = reduce_front(gain, prio_cs.amp_stage_priority);
			else if (gain.digital_gain_step != 3'h0)
				next_gain.digital_gain_step = gain.digital_gain_step - 3'h1;
		end
		else if (amp_valid && amp_level < target_db)
		begin
			if (gain.digital_gain_step < digital_max)
				next_gain.digital_gain_step = gain.digital_gain_step + 3'h1;
			else if (front_can_raise)
				next_gain = restore_front(gain, prio_cs.amp_stage_priority);
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			gain <= '{DIGITAL_TOP_STEP, 3'h0, 3'h0};
		end
		else
		begin
			gain <= next_gain;
		end
	end

	// ========================================
	// carrier sense
	logic        abs_enabled;
	logic        rel_enabled;
	logic [9:0]  abs_level;
	logic        abs_hit;
	logic        rel_hit;
	logic [7:0]  strength_ref;
	logic        ref_valid;
	logic [7:0]  next_strength_ref;
	logic        next_ref_valid;
	logic        next_carrier_sense;

	assign abs_enabled = prio_cs.absolute_cs_threshold != ABS_CS_DISABLE;
	assign rel_enabled = prio_cs.relative_cs_threshold != REL_CS_DISABLE;
	assign abs_level   = {2'h0, target_db}
		+ {{6{prio_cs.absolute_cs_threshold[3]}}, prio_cs.absolute_cs_threshold};
	assign abs_hit     = $signed({2'h0, received_strength_value}) >= $signed(abs_level);
	assign rel_hit     = ref_valid && ({1'b0, received_strength_value}
		>= {1'b0, strength_ref} + {1'b0, agccs_rel_db(prio_cs.relative_cs_threshold)});

	always_comb
	begin
		next_strength_ref  = strength_ref;
		next_ref_valid     = ref_valid;
		next_carrier_sense = carrier_sense;
		// reference tracks the quietest level seen since restart
		if (cs_restart || !rel_enabled)
		begin
			next_ref_valid = 1'b0;
		end
		else if (received_strength_value_valid && (!ref_valid || received_strength_value < strength_ref))
		begin
			next_strength_ref = received_strength_value;
			next_ref_valid    = 1'b1;
		end
		if (!abs_enabled && !rel_enabled)
		begin
			next_carrier_sense = 1'b0;
		end
		else if (received_strength_value_valid)
		begin
			next_carrier_sense = (abs_enabled && abs_hit) || (rel_enabled && rel_hit);
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			strength_ref  <= '0;
			ref_valid     <= 1'b0;
			carrier_sense <= 1'b0;
		end
		else
		begin
			strength_ref  <= next_strength_ref;
			ref_valid     <= next_ref_valid;
			carrier_sense <= next_carrier_sense;
		end
	end

endmodule

`default_nettype wire

// ==== verif/agccs_cfg_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module agccs_cfg_chk
	import agccs_pkg::*;
(
	// clock, reset, register port
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// gain loop and carrier sense
	input wire logic              amp_valid,
	input wire logic [7:0]        amp_level,
	input wire logic              received_strength_value_valid,
	input wire logic [7:0]        received_strength_value,
	input wire logic              cs_restart,
	input wire agccs_gain_t       gain,
	input wire logic              carrier_sense
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ========================================
	// shadow registers, updated on the same edge as the design's own
	localparam logic [7:0] TDB [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
	logic [7:0] ct;
	logic [7:0] pc;
	logic [2:0] lim;
	logic [3:0] fsum;
	logic [7:0] alvl;
	assign lim  = 3'h7 - {1'h0, ct[7:6]};
	assign fsum = {1'h0, gain.first_amp_reduction} + {1'h0, gain.second_amp_reduction};
	assign alvl = TDB[ct[2:0]] + {{4{pc[3]}}, pc[3:0]};
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ct <= GAIN_CEILING_TARGET_RST;
			pc <= PRIO_CS_RST;
		end
		else if (reg_wr && reg_addr == GAIN_CEILING_TARGET_OFS)
			ct <= reg_wdata;
		else if (reg_wr && reg_addr == PRIO_CS_OFS)
			pc <= reg_wdata & 8'h7f;
	end
	// ========================================
	// assertions
	property p_clamp;
		gain.digital_gain_step > lim |=> gain.digital_gain_step == $past(lim);
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("digital step not clamped");
	property p_front;
		gain.digital_gain_step <= lim && fsum < {1'h0, ct[5:3]} |=> fsum == $past(fsum) + 4'h1;
	endproperty
	a_front: assert property (p_front)
		else $error("front reduction not stepping to ceiling");
	property p_first;
		pc[6] && gain.first_amp_reduction < 3'h7
			|=> gain.second_amp_reduction <= $past(gain.second_amp_reduction);
	endproperty
	a_first: assert property (p_first)
		else $error("second stage reduced before first");
	property p_second;
		!pc[6] && gain.second_amp_reduction < 3'h7
			|=> gain.first_amp_reduction <= $past(gain.first_amp_reduction);
	endproperty
	a_second: assert property (p_second)
		else $error("first stage reduced before second at minimum");
	property p_off;
		pc[5:4] == REL_CS_DISABLE && pc[3:0] == ABS_CS_DISABLE |=> !carrier_sense;
	endproperty
	a_off: assert property (p_off)
		else $error("sense high with both thresholds off");
	property p_abs;
		received_strength_value_valid && pc[3:0] != ABS_CS_DISABLE && received_strength_value >= alvl
			|=> carrier_sense;
	endproperty
	a_abs: assert property (p_abs)
		else $error("sense missed at absolute level");
	property p_miss;
		received_strength_value_valid && pc[5:4] == REL_CS_DISABLE && received_strength_value < alvl
			|=> !carrier_sense;
	endproperty
	a_miss: assert property (p_miss)
		else $error("sense high below absolute level");
	property p_rd_ct;
		reg_rd && reg_addr == GAIN_CEILING_TARGET_OFS |=> reg_rdata == $past(ct);
	endproperty
	a_rd_ct: assert property (p_rd_ct)
		else $error("ceiling and target readback wrong");
	property p_rd_pc;
		reg_rd && reg_addr == PRIO_CS_OFS |=> reg_rdata == $past(pc);
	endproperty
	a_rd_pc: assert property (p_rd_pc)
		else $error("priority and sense readback wrong");
endmodule
bind agccs_cfg agccs_cfg_chk u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.amp_valid(amp_valid), .amp_level(amp_level), .received_strength_value_valid(received_strength_value_valid),
	.received_strength_value(received_strength_value), .cs_restart(cs_restart),
	.gain(gain), .carrier_sense(carrier_sense));
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb
	import agccs_pkg::*;
;
	logic        clk_sys = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [7:0]  reg_rdata;
	logic        amp_valid = 1'h0;
	logic        received_strength_value_valid = 1'h0;
	logic        cs_restart = 1'h0;
	logic [7:0]  amp_level = 8'h00;
	logic [7:0]  received_strength_value = 8'h00;
	agccs_gain_t gain;
	logic        carrier_sense;
	int          failures = 0;
	int          num_checks = 0;
	logic [7:0]  tdb [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
	logic [7:0]  rdb [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};
	logic [3:0]  thr [4] = '{4'h9, 4'h0, 4'h7, 4'h8};
	agccs_cfg dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .amp_valid(amp_valid),
		.amp_level(amp_level), .received_strength_value_valid(received_strength_value_valid), .cs_restart(cs_restart),
		.received_strength_value(received_strength_value), .gain(gain),
		.carrier_sense(carrier_sense));
	initial
		forever #25 clk_sys = ~clk_sys;
	// ========================================
	// bus and stimulus tasks
	task automatic do_reset;
		@(posedge clk_sys);
		rst <= 1'h1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask
	// one sample on the strength path or the amplitude path
	task automatic pulse(input logic rs, input logic [7:0] v);
		@(posedge clk_sys);
		amp_valid <= !rs;
		received_strength_value_valid <= rs;
		amp_level <= v;
		received_strength_value <= v;
		@(posedge clk_sys);
		amp_valid <= 1'h0;
		received_strength_value_valid <= 1'h0;
		#1;
	endtask
	// ========================================
	// scenarios
	task automatic t_regs;
		logic [7:0] v;
		rd(GAIN_CEILING_TARGET_OFS, v);
		`CHK(v, 8'h03)
		rd(PRIO_CS_OFS, v);
		`CHK(v, 8'h40)
		wr(PRIO_CS_OFS, 8'hff);
		rd(PRIO_CS_OFS, v);
		`CHK(v, 8'h7f)
		rd(8'h1d, v);
		`CHK(v, 8'h00)
		$display("t_regs done");
	endtask
	task automatic t_dig;
		for (int n = 0; n < 4; n++)
		begin
			wr(GAIN_CEILING_TARGET_OFS, {n[1:0], 6'h03});
			@(posedge clk_sys);
			#1;
			`CHK(gain.digital_gain_step, 3'h7 - n[2:0])
		end
		wr(GAIN_CEILING_TARGET_OFS, 8'h03);
		pulse(1'h0, 8'h00);
		`CHK(gain.digital_gain_step, 3'h5)
		$display("t_dig done");
	endtask
	task automatic t_tgt;
		for (int c = 0; c < 8; c++)
		begin
			wr(GAIN_CEILING_TARGET_OFS, {5'h00, c[2:0]});
			pulse(1'h0, tdb[c]);
			`CHK(gain.first_amp_reduction, 3'h0)
			pulse(1'h0, tdb[c] + 8'h01);
			`CHK(gain.first_amp_reduction, 3'h1)
			pulse(1'h0, tdb[c] - 8'h01);
			`CHK(gain.first_amp_reduction, 3'h0)
		end
		$display("t_tgt done");
	endtask
	task automatic t_prio;
		int es;
		wr(GAIN_CEILING_TARGET_OFS, 8'h38);
		repeat (9) @(posedge clk_sys);
		#1;
		`CHK(gain.first_amp_reduction, 3'h7)
		`CHK(gain.second_amp_reduction, 3'h0)
		do_reset;
		wr(PRIO_CS_OFS, 8'h08);
		wr(GAIN_CEILING_TARGET_OFS, 8'h10);
		for (int k = 0; k < 13; k++)
		begin
			if (k > 0)
				pulse(1'h0, 8'h60);
			else
			begin
				repeat (4) @(posedge clk_sys);
				#1;
			end
			es = 2 + k;
			`CHK(gain.second_amp_reduction, (es > 7) ? 3'h7 : es[2:0])
			`CHK(gain.first_amp_reduction, (es > 7) ? es[2:0] + 3'h1 : 3'h0)
		end
		pulse(1'h0, 8'h60);
		`CHK(gain.digital_gain_step, 3'h6)
		pulse(1'h0, 8'h00);
		`CHK(gain.digital_gain_step, 3'h7)
		pulse(1'h0, 8'h00);
		`CHK(gain.first_amp_reduction, 3'h6)
		`CHK(gain.second_amp_reduction, 3'h7)
		$display("t_prio done");
	endtask
	task automatic t_cs;
		logic [7:0] lvl;
		wr(GAIN_CEILING_TARGET_OFS, 8'h07);
		for (int i = 0; i < 4; i++)
		begin
			wr(PRIO_CS_OFS, {4'h4, thr[i]});
			lvl = 8'h2a + {{4{thr[i][3]}}, thr[i]};
			pulse(1'h1, lvl - 8'h01);
			`CHK(carrier_sense, 1'h0)
			pulse(1'h1, lvl);
			`CHK(carrier_sense, thr[i] != 4'h8)
		end
		for (int r = 0; r < 4; r++)
		begin
			wr(PRIO_CS_OFS, {2'h1, r[1:0], 4'h8});
			@(posedge clk_sys);
			cs_restart <= 1'h1;
			@(posedge clk_sys);
			cs_restart <= 1'h0;
			pulse(1'h1, 8'h14);
			pulse(1'h1, 8'h13 + rdb[r]);
			`CHK(carrier_sense, 1'h0)
			pulse(1'h1, 8'h14 + rdb[r]);
			`CHK(carrier_sense, r != 0)
		end
		$display("t_cs done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		do_reset;
		t_regs;
		do_reset;
		t_dig;
		do_reset;
		t_tgt;
		do_reset;
		t_prio;
		do_reset;
		t_cs;
		tally_and_finish;
	end
	// the whole run needs well under 2000 cycles
	initial
	begin
		#1000000;
		failures++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
